// file: common/spm_pkg.sv
// Constants shared by the switch power-mode controller.
// Assumes a 250 MHz reference clock and an AXI4-Lite register bus.
package spm_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ        = 250;
	localparam int PULSE_NS       = 120;
	localparam int PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int BEACON_MS      = 1000;
	localparam int BEACON_CYC     = BEACON_MS * CLK_MHZ * 1000;
	localparam int SLEEP_UNIT_US  = 1000;
	localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_US * CLK_MHZ;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam int         AXI_AW        = 10;
	localparam logic [7:0] IDX_PORT1_CTL = 8'h1D;
	localparam logic [7:0] IDX_PORT2_CTL = 8'h2D;
	localparam logic [7:0] IDX_GLOBAL    = 8'hC3;
	localparam logic [7:0] IDX_SLEEP     = 8'hC4;
	localparam logic [7:0] IDX_STATUS    = 8'hC5;
	localparam logic [7:0] IDX_AN_CTL    = 8'hC6;

	// ==========================================================
	// Field positions
	localparam int PORT_PD_BIT    = 3;
	localparam int MODE_LSB       = 4;
	localparam int AN_EN_BIT      = 0;
	localparam int STS_ENERGY_LSB = 4;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_PORT_CTL = 8'h00;
	localparam logic [7:0] RST_GLOBAL   = 8'h00;
	localparam logic [7:0] RST_SLEEP    = 8'h50;
	localparam logic [7:0] RST_AN_CTL   = 8'h01;

	// ==========================================================
	// Mode codes, bus answers and controller states
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_ENERGY = 2'h1;
	localparam logic [1:0] MODE_SOFT   = 2'h2;
	localparam logic [1:0] MODE_SAVING = 2'h3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_NORMAL,
		ST_ED_AWAKE,
		ST_ED_SLEEP,
		ST_SOFT,
		ST_SAVING,
		ST_CHIP_DOWN
	} spm_state_t;

endpackage : spm_pkg

// file: verilog/spm_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to the reference clock.
`timescale 1ns/1ps
`default_nettype none
module spm_sync #(
	parameter int               W       = 1,
	parameter logic [W-1:0]     RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] o;
	} spm_sync_st_t;

	spm_sync_st_t q;
	spm_sync_st_t n;

	// A bit changes only once stages two and three agree.
	always_comb begin
		n    = q;
		n.s1 = d_i;
		n.s2 = q.s1;
		n.s3 = q.s2;
		n.o  = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.o);
		if (!ce_i) begin
			n = q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			q <= n;
		end
	end

	assign q_o = q.o;

endmodule : spm_sync
`default_nettype wire

// file: verilog/spm_beacon.sv
// Line beacon: one short pulse at the start of every period while enabled.
// Assumes the enable comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module spm_beacon #(
	parameter int PERIOD = spm_pkg::BEACON_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	input  wire logic en_i,
	output logic      pulse_o
);

	typedef struct packed {
		logic [31:0] cnt;
		logic        pulse;
	} spm_beacon_st_t;

	spm_beacon_st_t q;
	spm_beacon_st_t n;
	logic [31:0]    hi_run;

	always_comb begin
		n = q;
		if (!en_i) begin
			n.cnt   = 32'h0;
			n.pulse = 1'b0;
		end else begin
			n.cnt   = (q.cnt == 32'(PERIOD - 1)) ? 32'h0 : q.cnt + 32'h1;
			n.pulse = q.cnt < 32'(spm_pkg::PULSE_CYC);
		end
		if (!ce_i) begin
			n = q;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign pulse_o = q.pulse;

	// ==========================================================
	// Checks
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hi_run <= 32'h0;
		end else if (ce_i) begin
			hi_run <= q.pulse ? hi_run + 32'h1 : 32'h0;
		end
	end

	property p_pulse_width;
		@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
		(en_i && $past(en_i) && $fell(q.pulse)) |-> hi_run == 32'(spm_pkg::PULSE_CYC);
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("beacon pulse width wrong");

endmodule : spm_beacon
`default_nettype wire

// file: verilog/spm_top.sv
// Power-mode controller of a three-port switch, with AXI4-Lite registers.
// Assumes the power-down pin and energy inputs are asynchronous pins.
//
// Summary of operation
// - Power-down pin low turns whole chip off.
// - Mode field picks normal, energy, soft, saving.
// - Port control bit 3 powers down that PHY.
// - Mode field resets to normal operation.
// - Saving keeps PLL, MAC, host; trims receiver.
// - Energy idle beyond sleep delay enters low power.
// - Low power leaves only receiver energy detection.
// - Low power emits 120 ns pulse each second.
// - Cable energy returns device to normal power.
// - Soft power down stops clocks, PHY, MAC.
// - Any host access wakes from soft down.
// - Saving needs mode 11, autonegotiation, no cable.
// - Saving keeps transmitter; activity restores receiver.
`timescale 1ns/1ps
`default_nettype none
module spm_top #(
	parameter int BEACON_CYC     = spm_pkg::BEACON_CYC,
	parameter int SLEEP_UNIT_CYC = spm_pkg::SLEEP_UNIT_CYC
) (
	input  wire logic                       REF_CLK_I,
	input  wire logic                       RST_N_I,
	input  wire logic                       CLK_EN_I,
	input  wire logic                       CHIP_POWERDOWN_N_I,
	input  wire logic [1:0]                 CABLE_ENERGY_I,
	input  wire logic [spm_pkg::AXI_AW-1:0] S_AXI_AWADDR_I,
	input  wire logic                       S_AXI_AWVALID_I,
	output logic                            S_AXI_AWREADY_O,
	input  wire logic [31:0]                S_AXI_WDATA_I,
	input  wire logic [3:0]                 S_AXI_WSTRB_I,
	input  wire logic                       S_AXI_WVALID_I,
	output logic                            S_AXI_WREADY_O,
	output logic [1:0]                      S_AXI_BRESP_O,
	output logic                            S_AXI_BVALID_O,
	input  wire logic                       S_AXI_BREADY_I,
	input  wire logic [spm_pkg::AXI_AW-1:0] S_AXI_ARADDR_I,
	input  wire logic                       S_AXI_ARVALID_I,
	output logic                            S_AXI_ARREADY_O,
	output logic [31:0]                     S_AXI_RDATA_O,
	output logic [1:0]                      S_AXI_RRESP_O,
	output logic                            S_AXI_RVALID_O,
	input  wire logic                       S_AXI_RREADY_I,
	output logic                            PLL_EN_O,
	output logic                            MAC_EN_O,
	output logic                            HOST_EN_O,
	output logic [1:0]                      PHY_PWR_EN_O,
	output logic [1:0]                      PHY_RX_FULL_O,
	output logic                            ENERGY_DET_EN_O,
	output logic                            LINE_PULSE_O
);

	typedef struct packed {
		spm_pkg::spm_state_t st;
		logic [7:0]          p1;
		logic [7:0]          p2;
		logic [7:0]          gpm;
		logic [7:0]          sleep;
		logic [7:0]          an;
		logic [31:0]         pre;
		logic [8:0]          idle;
		logic                awrdy;
		logic                wrdy;
		logic                aw_have;
		logic                w_have;
		logic [7:0]          aw_idx;
		logic [7:0]          wdat;
		logic                wstb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arrdy;
		logic                rvalid;
		logic [1:0]          rresp;
		logic [7:0]          rdata;
		logic                pll;
		logic                mac;
		logic                host;
		logic                edet;
		logic [1:0]          phy;
		logic [1:0]          rxf;
	} spm_regs_t;

	localparam spm_regs_t RST_REGS = '{
		st: spm_pkg::ST_NORMAL,
		p1: spm_pkg::RST_PORT_CTL,
		p2: spm_pkg::RST_PORT_CTL,
		gpm: spm_pkg::RST_GLOBAL,
		sleep: spm_pkg::RST_SLEEP,
		an: spm_pkg::RST_AN_CTL,
		awrdy: 1'b1,
		wrdy: 1'b1,
		arrdy: 1'b1,
		pll: 1'b1,
		mac: 1'b1,
		host: 1'b1,
		phy: 2'h3,
		rxf: 2'h3,
		default: '0
	};

	spm_regs_t  q;
	spm_regs_t  n;
	logic [2:0] sync_q;
	logic       pwr_n_s;
	logic [1:0] en_s;
	logic       aw_hs;
	logic       ar_hs;
	logic       wake;
	logic       host_ok;
	logic       expire;
	logic [1:0] pd;
	logic [1:0] mode;
	logic [7:0] ridx;

	// ==========================================================
	// Pin synchronisers
	spm_sync #(
		.W       (3),
		.RST_VAL (3'h1)
	) u_sync (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.ce_i    (CLK_EN_I),
		.d_i     ({CABLE_ENERGY_I, CHIP_POWERDOWN_N_I}),
		.q_o     (sync_q)
	);

	assign pwr_n_s = sync_q[0];
	assign en_s    = sync_q[2:1];

	// ==========================================================
	// Line beacon, running only in the low-power state
	spm_beacon #(
		.PERIOD  (BEACON_CYC)
	) u_beacon (
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.ce_i    (CLK_EN_I),
		.en_i    (q.edet),
		.pulse_o (LINE_PULSE_O)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		n       = q;
		aw_hs   = S_AXI_AWVALID_I && q.awrdy;
		ar_hs   = S_AXI_ARVALID_I && q.arrdy;
		// Soft power down has the host port off, yet an access must still wake it.
		wake    = (q.st == spm_pkg::ST_SOFT) && (aw_hs || ar_hs);
		host_ok = (q.st != spm_pkg::ST_ED_SLEEP) && (q.st != spm_pkg::ST_CHIP_DOWN);
		expire  = q.idle > {1'b0, q.sleep};
		ridx    = S_AXI_ARADDR_I[9:2];

		// Write address and data are taken independently, in either order.
		if (aw_hs) begin
			n.awrdy   = 1'b0;
			n.aw_have = 1'b1;
			n.aw_idx  = S_AXI_AWADDR_I[9:2];
		end
		if (S_AXI_WVALID_I && q.wrdy) begin
			n.wrdy   = 1'b0;
			n.w_have = 1'b1;
			n.wdat   = S_AXI_WDATA_I[7:0];
			n.wstb   = S_AXI_WSTRB_I[0];
		end
		if (wake) begin
			n.gpm[spm_pkg::MODE_LSB +: 2] = spm_pkg::MODE_NORMAL;
		end
		if (q.aw_have && q.w_have && !q.bvalid) begin
			n.bvalid = 1'b1;
			n.bresp  = spm_pkg::RESP_OKAY;
			if (!host_ok) begin
				n.bresp = spm_pkg::RESP_SLVERR;
			end else begin
				unique case (q.aw_idx)
					spm_pkg::IDX_PORT1_CTL: if (q.wstb) n.p1 = q.wdat;
					spm_pkg::IDX_PORT2_CTL: if (q.wstb) n.p2 = q.wdat;
					spm_pkg::IDX_GLOBAL:    if (q.wstb) n.gpm = q.wdat;
					spm_pkg::IDX_SLEEP:     if (q.wstb) n.sleep = q.wdat;
					spm_pkg::IDX_AN_CTL:    if (q.wstb) n.an = q.wdat;
					spm_pkg::IDX_STATUS:    n.bresp = spm_pkg::RESP_OKAY;
					default:                n.bresp = spm_pkg::RESP_SLVERR;
				endcase
			end
		end
		if (q.bvalid && S_AXI_BREADY_I) begin
			n.bvalid  = 1'b0;
			n.aw_have = 1'b0;
			n.w_have  = 1'b0;
			n.awrdy   = 1'b1;
			n.wrdy    = 1'b1;
		end

		// Read channel: data one cycle after the address is taken.
		if (ar_hs) begin
			n.arrdy  = 1'b0;
			n.rvalid = 1'b1;
			n.rresp  = spm_pkg::RESP_OKAY;
			n.rdata  = 8'h00;
			if (!host_ok) begin
				n.rresp = spm_pkg::RESP_SLVERR;
			end else begin
				unique case (ridx)
					spm_pkg::IDX_PORT1_CTL: n.rdata = q.p1;
					spm_pkg::IDX_PORT2_CTL: n.rdata = q.p2;
					spm_pkg::IDX_GLOBAL:    n.rdata = q.gpm;
					spm_pkg::IDX_SLEEP:     n.rdata = q.sleep;
					spm_pkg::IDX_AN_CTL:    n.rdata = q.an;
					spm_pkg::IDX_STATUS: begin
						n.rdata = {2'h0, en_s, 1'b0, q.st};
					end
					default:                n.rresp = spm_pkg::RESP_SLVERR;
				endcase
			end
		end
		if (q.rvalid && S_AXI_RREADY_I) begin
			n.rvalid = 1'b0;
			n.arrdy  = 1'b1;
		end

		// Idle timer counts whole sleep units with no cable energy.
		if ((q.st == spm_pkg::ST_ED_AWAKE) && (en_s == 2'h0)) begin
			if (q.pre == 32'(SLEEP_UNIT_CYC - 1)) begin
				n.pre = 32'h0;
				if (q.idle != 9'h1FF) begin
					n.idle = q.idle + 9'h1;
				end
			end else begin
				n.pre = q.pre + 32'h1;
			end
		end else begin
			n.pre  = 32'h0;
			n.idle = 9'h0;
		end

		// Global mode, from bits five to four of the mode register.
		mode = n.gpm[spm_pkg::MODE_LSB +: 2];
		if (!pwr_n_s) begin
			n.st = spm_pkg::ST_CHIP_DOWN;
		end else begin
			unique case (mode)
				spm_pkg::MODE_NORMAL: n.st = spm_pkg::ST_NORMAL;
				spm_pkg::MODE_ENERGY: begin
					if (q.st == spm_pkg::ST_ED_SLEEP) begin
						n.st = (en_s != 2'h0) ? spm_pkg::ST_ED_AWAKE : spm_pkg::ST_ED_SLEEP;
					end else if ((q.st == spm_pkg::ST_ED_AWAKE) && expire) begin
						n.st = spm_pkg::ST_ED_SLEEP;
					end else begin
						n.st = spm_pkg::ST_ED_AWAKE;
					end
				end
				spm_pkg::MODE_SOFT:   n.st = spm_pkg::ST_SOFT;
				spm_pkg::MODE_SAVING: n.st = spm_pkg::ST_SAVING;
			endcase
		end

		// Block enables follow the state entered at this edge.
		pd     = {n.p2[spm_pkg::PORT_PD_BIT], n.p1[spm_pkg::PORT_PD_BIT]};
		n.pll  = 1'b0;
		n.mac  = 1'b0;
		n.host = 1'b0;
		n.edet = 1'b0;
		n.phy  = 2'h0;
		n.rxf  = 2'h0;
		unique case (n.st)
			spm_pkg::ST_NORMAL, spm_pkg::ST_ED_AWAKE: begin
				n.pll  = 1'b1;
				n.mac  = 1'b1;
				n.host = 1'b1;
				n.phy  = ~pd;
				n.rxf  = ~pd;
			end
			spm_pkg::ST_SAVING: begin
				n.pll  = 1'b1;
				n.mac  = 1'b1;
				n.host = 1'b1;
				n.phy  = ~pd;
				// Receiver trimmed only with autonegotiation on and no energy on that port.
				n.rxf  = ~pd & ~({2{n.an[spm_pkg::AN_EN_BIT]}} & ~en_s);
			end
			spm_pkg::ST_ED_SLEEP: begin
				n.edet = 1'b1;
			end
			spm_pkg::ST_SOFT, spm_pkg::ST_CHIP_DOWN: begin
				n.edet = 1'b0;
			end
		endcase

		if (!CLK_EN_I) begin
			n = q;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			q <= RST_REGS;
		end else begin
			q <= n;
		end
	end

	assign S_AXI_AWREADY_O = q.awrdy;
	assign S_AXI_WREADY_O  = q.wrdy;
	assign S_AXI_BRESP_O   = q.bresp;
	assign S_AXI_BVALID_O  = q.bvalid;
	assign S_AXI_ARREADY_O = q.arrdy;
	assign S_AXI_RDATA_O   = {24'h0, q.rdata};
	assign S_AXI_RRESP_O   = q.rresp;
	assign S_AXI_RVALID_O  = q.rvalid;
	assign PLL_EN_O        = q.pll;
	assign MAC_EN_O        = q.mac;
	assign HOST_EN_O       = q.host;
	assign PHY_PWR_EN_O    = q.phy;
	assign PHY_RX_FULL_O   = q.rxf;
	assign ENERGY_DET_EN_O = q.edet;

	// ==========================================================
	// Checks
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I || !CLK_EN_I);

	sequence s_no_write;
		!(q.aw_have && q.w_have);
	endsequence

	sequence s_soft_access;
		q.st == spm_pkg::ST_SOFT && pwr_n_s && (aw_hs || ar_hs) ##0 s_no_write;
	endsequence

	sequence s_sleep_due;
		q.st == spm_pkg::ST_ED_AWAKE && expire && pwr_n_s && q.gpm[5:4] == spm_pkg::MODE_ENERGY ##0 s_no_write;
	endsequence

	property p_chip_down;
		!pwr_n_s |=> q.st == spm_pkg::ST_CHIP_DOWN && !PLL_EN_O && !HOST_EN_O && PHY_PWR_EN_O == 2'h0;
	endproperty
	a_chip_down: assert property (p_chip_down) else $error("chip not powered down");

	property p_mode_map;
		$past(pwr_n_s) && q.gpm[5:4] == spm_pkg::MODE_SOFT |-> q.st == spm_pkg::ST_SOFT;
	endproperty
	a_mode_map: assert property (p_mode_map) else $error("mode field not followed");

	property p_port_pd;
		q.st == spm_pkg::ST_NORMAL |-> PHY_PWR_EN_O == ~{q.p2[3], q.p1[3]};
	endproperty
	a_port_pd: assert property (p_port_pd) else $error("port power down ignored");

	property p_saving_keep;
		q.st == spm_pkg::ST_SAVING |-> PLL_EN_O && MAC_EN_O && HOST_EN_O;
	endproperty
	a_saving_keep: assert property (p_saving_keep) else $error("saving mode lost clocks");

	property p_sleep_entry;
		s_sleep_due |=> q.st == spm_pkg::ST_ED_SLEEP ##1 LINE_PULSE_O;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("low power not entered");

	property p_sleep_off;
		q.st == spm_pkg::ST_ED_SLEEP |-> !PLL_EN_O && !MAC_EN_O && !HOST_EN_O && ENERGY_DET_EN_O;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("low power left blocks on");

	property p_energy_wake;
		q.st == spm_pkg::ST_ED_SLEEP && en_s != 2'h0 && pwr_n_s && q.gpm[5:4] == spm_pkg::MODE_ENERGY
			##0 s_no_write |=> q.st == spm_pkg::ST_ED_AWAKE && HOST_EN_O;
	endproperty
	a_energy_wake: assert property (p_energy_wake) else $error("energy did not wake");

	property p_soft_off;
		q.st == spm_pkg::ST_SOFT |-> !PLL_EN_O && !MAC_EN_O && PHY_PWR_EN_O == 2'h0;
	endproperty
	a_soft_off: assert property (p_soft_off) else $error("soft down left blocks on");

	property p_soft_wake;
		s_soft_access |=> q.st == spm_pkg::ST_NORMAL && q.gpm[5:4] == spm_pkg::MODE_NORMAL;
	endproperty
	a_soft_wake: assert property (p_soft_wake) else $error("access did not wake");

	property p_saving_an;
		q.st == spm_pkg::ST_SAVING && !q.an[0] |-> PHY_RX_FULL_O == PHY_PWR_EN_O;
	endproperty
	a_saving_an: assert property (p_saving_an) else $error("receiver trimmed without autoneg");

	property p_saving_tx;
		q.st == spm_pkg::ST_SAVING |-> PHY_PWR_EN_O == ~{q.p2[3], q.p1[3]};
	endproperty
	a_saving_tx: assert property (p_saving_tx) else $error("transmitter off in saving");

	property p_idle_restart;
		en_s != 2'h0 |=> q.idle == 9'h0 && q.pre == 32'h0;
	endproperty
	a_idle_restart: assert property (p_idle_restart) else $error("sleep timer not restarted");

endmodule : spm_top
`default_nettype wire

// file: test/spm_cable.sv
// Cable link partner model: energy or activity on each copper port.
// Assumes the bench plugs and unplugs ports by level on plug_i.
`timescale 1ns/1ps
`default_nettype none
module spm_cable (
	input  wire logic       clk_i,
	input  wire logic [1:0] plug_i,
	output logic      [1:0] energy_o
);
	// The pair settles one cycle after a plug event; the pin is asynchronous to the device anyway.
	initial energy_o = 2'h0;
	always @(posedge clk_i) begin
		energy_o <= plug_i;
	end
endmodule : spm_cable
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the switch power-mode controller.
// Assumes the cable model above and short beacon and sleep-unit counts.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int BCN  = 200;
	localparam int UNIT = 4;
	localparam int PW   = 120 / 4;
	logic        ref_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        pd_n    = 1'b1;
	logic        ce      = 1'b1;
	logic [1:0]  plug    = 2'h0;
	logic [1:0]  energy;
	logic [9:0]  awaddr  = 10'h000;
	logic [9:0]  araddr  = 10'h000;
	logic [31:0] wdata   = 32'h0;
	logic        awv     = 1'b0;
	logic        wv      = 1'b0;
	logic        bready  = 1'b0;
	logic        arv     = 1'b0;
	logic        rready  = 1'b0;
	logic        awrdy, wrdy, bvalid, arrdy, rvalid;
	logic [1:0]  bresp, rresp, phy_pwr, rx_full;
	logic [31:0] rdata;
	logic        pll_en, mac_en, host_en, det_en, pulse;
	int          n_mismatch = 0;
	int          num_checks = 0;
	int          ticks      = 0;
	int          i, n, m;

	always #2 ref_clk = ~ref_clk;

	spm_cable cable (.clk_i(ref_clk), .plug_i(plug), .energy_o(energy));

	spm_top #(.BEACON_CYC(BCN), .SLEEP_UNIT_CYC(UNIT)) dut (
		.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .CLK_EN_I(ce), .CHIP_POWERDOWN_N_I(pd_n),
		.CABLE_ENERGY_I(energy), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
		.PLL_EN_O(pll_en), .MAC_EN_O(mac_en), .HOST_EN_O(host_en), .PHY_PWR_EN_O(phy_pwr),
		.PHY_RX_FULL_O(rx_full), .ENERGY_DET_EN_O(det_en), .LINE_PULSE_O(pulse)
	);

	// ==========================================================
	// Checking and bus tasks
	function automatic logic [31:0] pv();
		return {26'h0, pll_en, mac_en, host_en, phy_pwr, det_en};
	endfunction : pv

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic settle(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask : settle

	// Handshakes are judged at the falling edge so the rising edge that takes them is never raced.
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
		logic       haw, hw, hb;
		logic [1:0] resp;
		@(posedge ref_clk);
		awaddr <= {idx, 2'b00};
		wdata  <= d;
		awv    <= 1'b1;
		wv     <= 1'b1;
		bready <= 1'b1;
		hb = 1'b0;
		while (!hb) begin
			@(negedge ref_clk);
			haw  = awv && (awrdy === 1'b1);
			hw   = wv && (wrdy === 1'b1);
			hb   = bvalid === 1'b1;
			resp = bresp;
			@(posedge ref_clk);
			if (haw) awv <= 1'b0;
			if (hw) wv <= 1'b0;
			if (hb) bready <= 1'b0;
		end
		chk("bresp", {30'h0, er}, {30'h0, resp});
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
		logic        ha, hr;
		logic [1:0]  resp;
		logic [31:0] d;
		@(posedge ref_clk);
		araddr <= {idx, 2'b00};
		arv    <= 1'b1;
		rready <= 1'b1;
		hr = 1'b0;
		while (!hr) begin
			@(negedge ref_clk);
			ha   = arv && (arrdy === 1'b1);
			hr   = rvalid === 1'b1;
			resp = rresp;
			d    = rdata;
			@(posedge ref_clk);
			if (ha) arv <= 1'b0;
			if (hr) rready <= 1'b0;
		end
		chk("rresp", {30'h0, er}, {30'h0, resp});
		chk("rdata", exp, d);
	endtask : rd

	task automatic results;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	// A hang anywhere ends the run as a failure.
	always @(posedge ref_clk) begin
		ticks <= ticks + 1;
		if (ticks == 20000) begin
			n_mismatch++;
			results();
		end
	end

	// ==========================================================
	// Scenarios
	initial begin
		settle(5);
		chk("power_in_reset", 32'h3E, pv());
		settle(4);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		settle(6);
		chk("power_after_reset", 32'h3E, pv());
		rd(spm_pkg::IDX_GLOBAL, 32'h00, spm_pkg::RESP_OKAY);
		rd(spm_pkg::IDX_PORT1_CTL, 32'h00, spm_pkg::RESP_OKAY);
		rd(spm_pkg::IDX_SLEEP, 32'h50, spm_pkg::RESP_OKAY);
		rd(8'h00, 32'h0, spm_pkg::RESP_SLVERR);
		wr(8'h01, 32'h5A, spm_pkg::RESP_SLVERR);
		// Per-port power down, port 1 alone and then both together.
		wr(spm_pkg::IDX_PORT1_CTL, 32'h08, spm_pkg::RESP_OKAY);
		settle(2);
		chk("phy_pwr_p1", 32'h2, {30'h0, phy_pwr});
		wr(spm_pkg::IDX_PORT2_CTL, 32'h08, spm_pkg::RESP_OKAY);
		settle(2);
		chk("phy_pwr_both", 32'h0, {30'h0, phy_pwr});
		wr(spm_pkg::IDX_PORT1_CTL, 32'h40, spm_pkg::RESP_OKAY);
		wr(spm_pkg::IDX_PORT2_CTL, 32'h00, spm_pkg::RESP_OKAY);
		settle(2);
		chk("phy_pwr_on", 32'h3, {30'h0, phy_pwr});
		// Power saving with both cables out, then activity on port 1.
		wr(spm_pkg::IDX_GLOBAL, 32'h30, spm_pkg::RESP_OKAY);
		settle(8);
		chk("saving_power", 32'h3E, pv());
		chk("saving_rx", 32'h0, {30'h0, rx_full});
		wr(spm_pkg::IDX_STATUS, 32'hFF, spm_pkg::RESP_OKAY);
		rd(spm_pkg::IDX_STATUS, 32'h04, spm_pkg::RESP_OKAY);
		// With the clock enable low the controller must not notice the cable at all.
		@(posedge ref_clk);
		ce   <= 1'b0;
		plug <= 2'b01;
		settle(8);
		chk("rx_frozen", 32'h0, {30'h0, rx_full});
		@(posedge ref_clk);
		ce <= 1'b1;
		settle(8);
		chk("saving_rx_wake", 32'h1, {30'h0, rx_full});
		plug <= 2'b00;
		wr(spm_pkg::IDX_AN_CTL, 32'h00, spm_pkg::RESP_OKAY);
		settle(8);
		chk("saving_no_autoneg", 32'h3, {30'h0, rx_full});
		wr(spm_pkg::IDX_AN_CTL, 32'h01, spm_pkg::RESP_OKAY);
		// Soft power down straight from power saving, woken by a write.
		wr(spm_pkg::IDX_GLOBAL, 32'h20, spm_pkg::RESP_OKAY);
		settle(2);
		chk("soft_power", 32'h0, {28'h0, pll_en, mac_en, phy_pwr});
		wr(spm_pkg::IDX_SLEEP, 32'h02, spm_pkg::RESP_OKAY);
		settle(2);
		chk("soft_wake", 32'h3E, pv());
		rd(spm_pkg::IDX_GLOBAL, 32'h00, spm_pkg::RESP_OKAY);
		rd(spm_pkg::IDX_PORT1_CTL, 32'h40, spm_pkg::RESP_OKAY);
		rd(spm_pkg::IDX_SLEEP, 32'h02, spm_pkg::RESP_OKAY);
		// Energy detect: idle cable sleeps, beacon runs, activity wakes.
		wr(spm_pkg::IDX_GLOBAL, 32'h10, spm_pkg::RESP_OKAY);
		for (i = 0; i < 400 && det_en !== 1'b1; i++) @(negedge ref_clk);
		chk("ed_sleep", 32'h01, pv());
		for (i = 0; i < 400 && pulse !== 1'b1; i++) @(negedge ref_clk);
		for (n = 0; n < 1000 && pulse === 1'b1; n++) @(negedge ref_clk);
		chk("pulse_width", PW, n);
		for (m = 0; m < 1000 && pulse !== 1'b1; m++) @(negedge ref_clk);
		chk("pulse_period", BCN, n + m);
		rd(spm_pkg::IDX_GLOBAL, 32'h0, spm_pkg::RESP_SLVERR);
		plug <= 2'b10;
		for (i = 0; i < 40 && det_en !== 1'b0; i++) @(negedge ref_clk);
		settle(2);
		chk("ed_wake", 32'h3E, pv());
		settle(100);
		chk("ed_stay_awake", 32'h3E, pv());
		plug <= 2'b00;
		for (i = 0; i < 400 && det_en !== 1'b1; i++) @(negedge ref_clk);
		chk("ed_sleep_again", 32'h01, pv());
		plug <= 2'b01;
		settle(20);
		wr(spm_pkg::IDX_GLOBAL, 32'h00, spm_pkg::RESP_OKAY);
		// Hardware power-down pin.
		@(posedge ref_clk);
		pd_n <= 1'b0;
		settle(8);
		chk("chip_down", 32'h0, pv());
		rd(spm_pkg::IDX_GLOBAL, 32'h0, spm_pkg::RESP_SLVERR);
		@(posedge ref_clk);
		pd_n <= 1'b1;
		settle(8);
		// A hardware reset in mid-run must bring the mode field back to normal.
		wr(spm_pkg::IDX_GLOBAL, 32'h30, spm_pkg::RESP_OKAY);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		settle(3);
		chk("power_in_reset2", 32'h3E, pv());
		@(posedge ref_clk);
		rst_n <= 1'b1;
		settle(6);
		rd(spm_pkg::IDX_GLOBAL, 32'h00, spm_pkg::RESP_OKAY);
		rd(spm_pkg::IDX_STATUS, 32'h10, spm_pkg::RESP_OKAY);
		results();
	end
endmodule : testbench
`default_nettype wire
